// File: tb.sv
`timescale 1ns/1ns
module tb;
   logic              clk_sys_i = 1'b0;
   logic              resetn_i  = 1'b0;
   tpr_pkg::tpr_req_t req       = '0;
   logic              ack, err, defined;
   logic [31:0]       rdata;
   logic [3:0]        shown, exp_shown;
   tpr_pkg::tpr_cfg_t cfg;
   logic [31:0]       m [6];
   int                fail_count, total_checks, cycles, seed, i, k;
   logic [31:0]       bad_ofs [4] = '{32'h0000_0014, 32'h0000_0008, 32'h0000_0020, 32'h0000_0002};

   always #10 clk_sys_i = ~clk_sys_i;

   tpr_video_test_pattern_regs uut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .req_i(req),
      .ack_o(ack), .err_o(err), .rdata_o(rdata), .cfg_o(cfg), .pattern_defined_o(defined));
   tpr_gen_model gen (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .cfg_i(cfg),
      .defined_i(defined), .shown_o(shown));

   // Compares one result, wide fields zero-extended.
   task automatic chk(input logic [127:0] got, input logic [127:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   // Settings expected from the reference register copy.
   function automatic tpr_pkg::tpr_cfg_t exp_cfg();
      return {m[0][13:0], m[1][0], m[1][8:1], m[2][27:16], m[2][11:0], m[3],
              m[4][11:0], m[5][23:0]};
   endfunction

   // One load or store, answer checked in the cycle after it is taken.
   task automatic access(input logic wr, input logic [31:0] ofs, input logic [31:0] d,
                         input logic [31:0] exp_rd, input logic exp_err);
      @(negedge clk_sys_i);
      req <= {1'b1, wr, tpr_pkg::TPR_BASE_ADDR + ofs, d};
      @(negedge clk_sys_i);
      req.valid <= 1'b0;
      chk(ack, 1'b1);
      chk(err, exp_err);
      chk(rdata, exp_rd);
   endtask

   task automatic wr_reg(input int n, input logic [31:0] d);
      m[n] = d & tpr_pkg::TPR_MASK[n];
      access(1'b1, tpr_pkg::TPR_OFS[n], d, 32'h0000_0000, 1'b0);
   endtask

   task automatic rd_reg(input int n);
      access(1'b0, tpr_pkg::TPR_OFS[n], 32'h0000_0000, m[n], 1'b0);
   endtask

   // Store followed at once by a load of the same word, with no idle cycle between.
   task automatic wr_rd_pair(input int n, input logic [31:0] d);
      m[n] = d & tpr_pkg::TPR_MASK[n];
      @(negedge clk_sys_i);
      req <= {1'b1, 1'b1, tpr_pkg::TPR_BASE_ADDR + tpr_pkg::TPR_OFS[n], d};
      @(negedge clk_sys_i);
      req <= {1'b1, 1'b0, tpr_pkg::TPR_BASE_ADDR + tpr_pkg::TPR_OFS[n], 32'h0000_0000};
      chk(ack, 1'b1);
      chk(rdata, 32'h0000_0000);
      @(negedge clk_sys_i);
      req.valid <= 1'b0;
      chk(ack, 1'b1);
      chk(rdata, m[n]);
   endtask

   task automatic finish_test();
      $display("checks=%0d mismatches=%0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Cuts a hung run short.
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         finish_test();
      end
   end

   // Main sequence: reset values, random fields, all pattern codes, bad addresses.
   initial begin
      seed = $urandom(37422);
      foreach (m[n]) m[n] = 32'h0000_0000;
      repeat (8) @(posedge clk_sys_i);
      @(negedge clk_sys_i);
      resetn_i = 1'b1;
      chk(defined, 1'b1);
      chk(ack, 1'b0);
      chk(rdata, 32'h0000_0000);
      for (i = 0; i < 6; i++) rd_reg(i);
      chk(cfg, exp_cfg());
      for (k = 0; k < 3; k++) begin
         for (i = 0; i < 6; i++) wr_reg(i, $urandom);
         for (i = 0; i < 6; i++) rd_reg(i);
         chk(cfg, exp_cfg());
      end
      for (i = 0; i < 6; i++) wr_rd_pair(i, $urandom);
      chk(cfg, exp_cfg());
      for (k = 0; k < 16; k++) begin
         wr_reg(0, ($urandom & 32'hFFFF_FFF0) | k);
         chk(defined, k <= 10);
         chk(cfg, exp_cfg());
         rd_reg(0);
         if (k <= 10) begin
            exp_shown = 4'(k);
         end
         chk(shown, exp_shown);
      end
      foreach (bad_ofs[n]) begin
         access(1'b1, bad_ofs[n], $urandom, 32'h0000_0000, 1'b1);
         access(1'b0, bad_ofs[n], 32'h0000_0000, 32'h0000_0000, 1'b1);
      end
      chk(cfg, exp_cfg());
      for (i = 0; i < 6; i++) rd_reg(i);
      resetn_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
      resetn_i = 1'b1;
      foreach (m[n]) m[n] = 32'h0000_0000;
      chk(cfg, exp_cfg());
      chk(shown, 4'h0);
      chk(ack, 1'b0);
      for (i = 0; i < 6; i++) rd_reg(i);
      finish_test();
   end
endmodule

// File: tpr_gen_model.sv
`timescale 1ns/1ns
// Far-side generator model: follows only the pattern code it is handed, but holds on
// to the last defined pattern so an undefined code never reaches the picture.
module tpr_gen_model (
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   // Settings from the register bank.
   input  wire tpr_pkg::tpr_cfg_t cfg_i,
   input  wire logic              defined_i,
   // Pattern currently shown.
   output logic [3:0]             shown_o
);
   // Takes up a new pattern only when its code is defined.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) shown_o <= 4'h0;
      else if (defined_i) shown_o <= cfg_i.pattern;
   end
endmodule

// File: tpr_pkg.sv
package tpr_pkg;

   // ------------------------------------------------------------
   // Address map
   // ------------------------------------------------------------
   localparam logic [31:0] TPR_BASE_ADDR   = 32'h4008_0000;
   localparam int          TPR_NREG        = 6;
   localparam logic [2:0]  TPR_IDX_NONE    = 3'h7;
   localparam logic [31:0] TPR_OFS_PATTERN = 32'h0000_0000;
   localparam logic [31:0] TPR_OFS_MOTION  = 32'h0000_0004;
   localparam logic [31:0] TPR_OFS_FRAME   = 32'h0000_000C;
   localparam logic [31:0] TPR_OFS_ZP_H    = 32'h0000_0010;
   localparam logic [31:0] TPR_OFS_BOX_SZ  = 32'h0000_0018;
   localparam logic [31:0] TPR_OFS_BOX_COL = 32'h0000_001C;

   // ------------------------------------------------------------
   // Writable bits of each register, and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] TPR_MASK_PATTERN = 32'h0000_3FFF;
   localparam logic [31:0] TPR_MASK_MOTION  = 32'h0000_01FF;
   localparam logic [31:0] TPR_MASK_FRAME   = 32'h0FFF_0FFF;
   localparam logic [31:0] TPR_MASK_ZP_H    = 32'hFFFF_FFFF;
   localparam logic [31:0] TPR_MASK_BOX_SZ  = 32'h0000_0FFF;
   localparam logic [31:0] TPR_MASK_BOX_COL = 32'h00FF_FFFF;
   localparam logic [31:0] TPR_RESET_VAL    = 32'h0000_0000;

   localparam logic [31:0] TPR_OFS  [TPR_NREG] = '{TPR_OFS_PATTERN, TPR_OFS_MOTION,
      TPR_OFS_FRAME, TPR_OFS_ZP_H, TPR_OFS_BOX_SZ, TPR_OFS_BOX_COL};
   localparam logic [31:0] TPR_MASK [TPR_NREG] = '{TPR_MASK_PATTERN, TPR_MASK_MOTION,
      TPR_MASK_FRAME, TPR_MASK_ZP_H, TPR_MASK_BOX_SZ, TPR_MASK_BOX_COL};

   // ------------------------------------------------------------
   // Pattern codes
   // ------------------------------------------------------------
   localparam logic [3:0] TPR_PAT_PASS   = 4'h0;
   localparam logic [3:0] TPR_PAT_ZPLATE = 4'hA;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } tpr_req_t;

   typedef struct packed {
      logic        hblank_pol;
      logic        vblank_pol;
      logic        hsync_pol;
      logic        vsync_pol;
      logic        box_en;
      logic [2:0]  comp_mask;
      logic        chroma_pol;
      logic        xhair_en;
      logic [3:0]  pattern;
      logic        motion_en;
      logic [7:0]  motion_speed;
      logic [11:0] frame_height;
      logic [11:0] line_len;
      logic [15:0] zp_h_start;
      logic [15:0] zp_h_inc;
      logic [11:0] box_size;
      logic [23:0] box_color;
   } tpr_cfg_t;

endpackage

// File: tpr_video_test_pattern_regs.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Registers sit in processor memory map at base 0x40080000, plain loads and stores.
// - No interrupt; everything is configured through memory-mapped register accesses.
// - Settings steer the generator whose frames the frame DMA writes into DDR.
// - Bits 3:0 of offset 0x00 select the pattern, codes 0000 to 1010.
// - Offset 0x00 also holds polarities, box enable, component mask, chroma, crosshair.
// - Offset 0x04 holds motion enable bit 0 and motion speed bits 8:1.
// - Offset 0x0C holds line length bits 11:0 and frame height bits 27:16.
// - Offset 0x10 holds zone-plate delta start 31:16 and increment 15:0.
// - Every defined field is read-write and resets to zero.
// - Box size is 12 bits at 0x18, box colour 24 bits at 0x1C.
module tpr_video_test_pattern_regs #(
   parameter logic [31:0] BASE_ADDR = tpr_pkg::TPR_BASE_ADDR
) (
   // Clock and reset.
   input  wire logic              clk_sys_i,
   input  wire logic              resetn_i,
   // Processor load and store port.
   input  wire tpr_pkg::tpr_req_t req_i,
   output logic                   ack_o,
   output logic                   err_o,
   output logic [31:0]            rdata_o,
   // Settings to the pattern generator.
   output tpr_pkg::tpr_cfg_t      cfg_o,
   output logic                   pattern_defined_o
);

   // ------------------------------------------------------------
   // Elaboration check
   // ------------------------------------------------------------
   if (BASE_ADDR[4:0] != 5'h00) begin : g_bad_base
      $error("Base address must be aligned to 32 bytes.");
   end

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   // Returns the register index that an absolute address hits, or none.
   // An address below the base wraps far above every offset, so it decodes to none.
   function automatic logic [2:0] tpr_decode(input logic [31:0] addr);
      logic [31:0] rel;
      logic [2:0]  idx;
      rel = addr - BASE_ADDR;
      idx = tpr_pkg::TPR_IDX_NONE;
      for (int k = 0; k < tpr_pkg::TPR_NREG; k++) begin
         if (rel == tpr_pkg::TPR_OFS[k]) begin
            idx = 3'(k);
         end
      end
      return idx;
   endfunction

   logic [31:0] regs_r [tpr_pkg::TPR_NREG];
   logic        ack_r;
   logic        err_r;
   logic [31:0] rdata_r;
   wire  [2:0]  hit_idx;
   wire         hit;
   wire         wr_any;
   wire  [31:0] rd_word;

   // Decode of the request on the port; stores and loads share one path.
   assign hit_idx = tpr_decode(req_i.addr);
   assign hit     = (hit_idx != tpr_pkg::TPR_IDX_NONE);
   assign wr_any  = req_i.valid & req_i.write & hit;
   assign rd_word = hit ? regs_r[hit_idx] : 32'h0000_0000;

   // ------------------------------------------------------------
   // Register storage
   // ------------------------------------------------------------
   // Each word keeps only its defined bits, so reserved bits never hold a one.
   for (genvar i = 0; i < tpr_pkg::TPR_NREG; i++) begin : g_reg
      wire wr_this;
      assign wr_this = wr_any & (hit_idx == 3'(i));
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
         if (!resetn_i) begin
            regs_r[i] <= tpr_pkg::TPR_RESET_VAL;
         end else if (wr_this) begin
            regs_r[i] <= req_i.wdata & tpr_pkg::TPR_MASK[i];
         end
      end
   end

   // ------------------------------------------------------------
   // Answer path
   // ------------------------------------------------------------
   // Every request is answered one cycle later; unmapped ones read zero and flag an error.
   always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ack_r   <= 1'b0;
         err_r   <= 1'b0;
         rdata_r <= tpr_pkg::TPR_RESET_VAL;
      end else begin
         ack_r   <= req_i.valid;
         err_r   <= req_i.valid & ~hit;
         rdata_r <= (req_i.valid & ~req_i.write) ? rd_word : 32'h0000_0000;
      end
   end

   assign ack_o   = ack_r;
   assign err_o   = err_r;
   assign rdata_o = rdata_r;

   // ------------------------------------------------------------
   // Settings fan-out to the generator
   // ------------------------------------------------------------
   // Field slices of the stored words; the generator feeds the frame DMA.
   assign cfg_o.hblank_pol   = regs_r[0][13];
   assign cfg_o.vblank_pol   = regs_r[0][12];
   assign cfg_o.hsync_pol    = regs_r[0][11];
   assign cfg_o.vsync_pol    = regs_r[0][10];
   assign cfg_o.box_en       = regs_r[0][9];
   assign cfg_o.comp_mask    = regs_r[0][8:6];
   assign cfg_o.chroma_pol   = regs_r[0][5];
   assign cfg_o.xhair_en     = regs_r[0][4];
   assign cfg_o.pattern      = regs_r[0][3:0];
   assign cfg_o.motion_en    = regs_r[1][0];
   assign cfg_o.motion_speed = regs_r[1][8:1];
   assign cfg_o.frame_height = regs_r[2][27:16];
   assign cfg_o.line_len     = regs_r[2][11:0];
   assign cfg_o.zp_h_start   = regs_r[3][31:16];
   assign cfg_o.zp_h_inc     = regs_r[3][15:0];
   assign cfg_o.box_size     = regs_r[4][11:0];
   assign cfg_o.box_color    = regs_r[5][23:0];

   // Codes above zone plate are stored as written but marked undefined.
   assign pattern_defined_o = (regs_r[0][3:0] <= tpr_pkg::TPR_PAT_ZPLATE);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   // Each property samples on the rising edge and stays quiet while reset is held.
   a_ack_one_cycle: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      req_i.valid |=> ack_o)
      else $error("Request not answered in one cycle.");

   a_no_spurious_ack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !req_i.valid |=> !ack_o)
      else $error("Answer without a request.");

   a_write_readback: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i.valid && req_i.write && hit) ##1 (req_i.valid && !req_i.write
         && hit_idx == $past(hit_idx))
      |=> rdata_o == ($past(req_i.wdata, 2) & tpr_pkg::TPR_MASK[$past(hit_idx, 2)]))
      else $error("Read back differs from masked written value.");

   a_unmapped_read: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i.valid && !hit) |=> (err_o && rdata_o == 32'h0000_0000))
      else $error("Unmapped access not flagged or read nonzero.");

   a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      ack_o && !err_o |-> (rdata_o & ~tpr_pkg::TPR_MASK[$past(hit_idx)]) == 32'h0000_0000)
      else $error("Reserved bits read as one.");

   a_pattern_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h0) |=> cfg_o.pattern == $past(req_i.wdata[3:0]))
      else $error("Pattern select did not follow write.");

   a_polarity_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h0) |=> (cfg_o.hblank_pol == $past(req_i.wdata[13])
         && cfg_o.comp_mask == $past(req_i.wdata[8:6])))
      else $error("Polarity or mask field misplaced.");

   a_motion_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h1) |=> (cfg_o.motion_en == $past(req_i.wdata[0])
         && cfg_o.motion_speed == $past(req_i.wdata[8:1])))
      else $error("Motion fields misplaced.");

   a_frame_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h2) |=> (cfg_o.frame_height == $past(req_i.wdata[27:16])
         && cfg_o.line_len == $past(req_i.wdata[11:0])))
      else $error("Frame size fields misplaced.");

   a_zplate_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h3) |=> (cfg_o.zp_h_start == $past(req_i.wdata[31:16])
         && cfg_o.zp_h_inc == $past(req_i.wdata[15:0])))
      else $error("Zone plate fields misplaced.");

   a_box_fields: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h5) |=> cfg_o.box_color == $past(req_i.wdata[23:0]))
      else $error("Box colour not stored.");

   a_hold_no_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !(req_i.valid && req_i.write) |=> $stable(cfg_o))
      else $error("Settings changed without a write.");

   a_undef_pattern: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h0 && req_i.wdata[3:0] > 4'hA) |=> (!pattern_defined_o
         && $stable(cfg_o.motion_speed)))
      else $error("Undefined pattern code handled wrongly.");

   a_box_size: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h4) |=> cfg_o.box_size == $past(req_i.wdata[11:0]))
      else $error("Box size not stored.");

   a_overlay_write: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (wr_any && hit_idx == 3'h0) |=> (cfg_o.vblank_pol == $past(req_i.wdata[12])
         && cfg_o.hsync_pol == $past(req_i.wdata[11])
         && cfg_o.vsync_pol == $past(req_i.wdata[10])
         && cfg_o.box_en == $past(req_i.wdata[9])
         && cfg_o.chroma_pol == $past(req_i.wdata[5])
         && cfg_o.xhair_en == $past(req_i.wdata[4])))
      else $error("Sync, blank or overlay bit misplaced.");

   a_mapped_no_err: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i.valid && hit) |=> !err_o)
      else $error("Mapped access flagged as error.");

   a_err_with_ack: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      err_o |-> ack_o)
      else $error("Error flag without an answer.");

   a_store_no_data: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i.valid && req_i.write) |=> rdata_o == 32'h0000_0000)
      else $error("Store answered with nonzero data.");

   a_idle_data_zero: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      !req_i.valid |=> rdata_o == 32'h0000_0000)
      else $error("Load data stood longer than one cycle.");

   a_unmapped_store: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
      (req_i.valid && req_i.write && !hit) |=> $stable(cfg_o))
      else $error("Unmapped store changed the settings.");

endmodule
